// *** src/trig_mask_pkg.sv ***
// Shared constants for the trigger source mask logic.
package trig_mask_pkg;
    // Register port address width and data width.
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register numbers as the driver sees them.
    localparam logic [15:0] OFS_GEN_OR_AVAIL  = 16'h9dd0;  // General OR availability, RO.
    localparam logic [15:0] OFS_GEN_OR_SELECT = 16'h9dda;  // General OR select, RW.
    localparam logic [15:0] OFS_AND_AVAIL     = 16'h9de4;  // General AND availability, RO.
    localparam logic [15:0] OFS_AND_SELECT    = 16'h9dee;  // General AND select, RW.
    localparam logic [15:0] OFS_CH_OR_AVAIL   = 16'h9e02;  // Channel OR availability, RO.
    localparam logic [15:0] OFS_CH_OR_SELECT  = 16'h9e0c;  // Channel OR select, RW.

    // Bit positions of the general sources.
    localparam int unsigned SOFT_TRIGGER_POS = 0;
    localparam int unsigned ANALOG_EXT_POS   = 1;
    localparam int unsigned TTL_EXT_A_POS    = 2;
    localparam int unsigned TTL_EXT_B_POS    = 3;

    // Mask values of single sources.
    localparam logic [31:0] NO_SOURCE_CODE   = 32'h0000_0000;
    localparam logic [31:0] SOFT_TRIGGER_BIT = 32'h0000_0001;
    localparam logic [31:0] ANALOG_EXT_BIT   = 32'h0000_0002;
    localparam logic [31:0] TTL_EXT_A_BIT    = 32'h0000_0004;
    localparam logic [31:0] TTL_EXT_B_BIT    = 32'h0000_0008;

    // Sources that each general mask can hold.
    localparam logic [31:0] GEN_OR_AVAIL = 32'h0000_000f;
    localparam logic [31:0] AND_AVAIL    = 32'h0000_000e;

    // Values after reset.
    localparam logic [31:0] GEN_OR_RESET = SOFT_TRIGGER_BIT;
    localparam logic [31:0] AND_RESET    = NO_SOURCE_CODE;
    localparam logic [31:0] CH_OR_RESET  = NO_SOURCE_CODE;

    // Number of external inputs that arrive from pins.
    localparam int unsigned EXT_PINS = 3;
endpackage

// *** src/trig_src_if.sv ***
// Carrier between the register side and the trigger combiner.
`timescale 1ns/1ps
interface trig_src_if;
    logic [31:0] gen_or_mask;   // General OR selection.
    logic [31:0] and_mask;      // General AND selection.
    logic [31:0] chan_or_mask;  // Channel OR selection.
    logic [31:0] chan_trig;     // Channel trigger events.
    logic        soft_trig;     // Software trigger level.
    logic        analog_ext;    // Synchronised analog comparator.
    logic        ttl_ext_a;     // Synchronised TTL input A.
    logic        ttl_ext_b;     // Synchronised TTL input B.
    logic        line_a_trig;   // Multi line A set as trigger input.
    logic        line_b_trig;   // Multi line B set as trigger input.
    logic        or_hit;        // Registered OR result.
    logic        and_hit;       // Registered AND result.
    logic        trig;          // Registered final trigger.

    // Register side drives masks and sources.
    modport regs (output gen_or_mask, and_mask, chan_or_mask, chan_trig, soft_trig,
                  analog_ext, ttl_ext_a, ttl_ext_b, line_a_trig, line_b_trig,
                  input or_hit, and_hit, trig);
    // Combiner reads them and drives the results.
    modport comb (input gen_or_mask, and_mask, chan_or_mask, chan_trig, soft_trig,
                  analog_ext, ttl_ext_a, ttl_ext_b, line_a_trig, line_b_trig,
                  output or_hit, and_hit, trig);
endinterface

// *** src/pin_sync.sv ***
// Two stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);
    // Both stages held in one state word.
    typedef struct packed {
        logic [WIDTH-1:0] first;   // Metastable stage, read only by the second.
        logic [WIDTH-1:0] second;  // Settled copy.
    } state_s;

    state_s state_q;
    state_s state_d;

    // Width must be at least one.
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync needs WIDTH of at least one");
    end

    // Next state: shift the pin through both stages.
    always_comb begin
        state_d        = state_q;
        state_d.first  = pin_i;
        state_d.second = state_q.first;
    end

    // State register with asynchronous clear.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.second;
endmodule

// *** src/trig_combine.sv ***
// Combines enabled trigger sources into OR, AND and final trigger.
`timescale 1ns/1ps
module trig_combine (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    trig_src_if.comb  src
);
    // Registered results of the combination.
    typedef struct packed {
        logic or_hit;   // Some OR-enabled source is active.
        logic and_hit;  // Every AND-enabled source is active.
        logic trig;     // Final trigger.
    } state_s;

    state_s      state_q;
    state_s      state_d;
    logic [31:0] ext_now;  // General sources in mask bit order.
    logic [31:0] and_src;  // Sources that the AND mask may see.

    // Gather sources; TTL lines count only when set as trigger inputs.
    always_comb begin
        ext_now = trig_mask_pkg::NO_SOURCE_CODE;
        ext_now[trig_mask_pkg::SOFT_TRIGGER_POS] = src.soft_trig;
        ext_now[trig_mask_pkg::ANALOG_EXT_POS]   = src.analog_ext;
        ext_now[trig_mask_pkg::TTL_EXT_A_POS]    = src.ttl_ext_a & src.line_a_trig;
        ext_now[trig_mask_pkg::TTL_EXT_B_POS]    = src.ttl_ext_b & src.line_b_trig;
        // The software event never reaches the AND side.
        and_src = ext_now & trig_mask_pkg::AND_AVAIL;
    end

    // Next state of the combination.
    always_comb begin
        state_d        = state_q;
        state_d.or_hit = (|(src.gen_or_mask & ext_now)) | (|(src.chan_or_mask & src.chan_trig));
        // An empty AND mask selects nothing and never fires.
        state_d.and_hit = (src.and_mask != trig_mask_pkg::NO_SOURCE_CODE)
                          && ((src.and_mask & ~and_src) == trig_mask_pkg::NO_SOURCE_CODE);
        state_d.trig    = state_d.or_hit | state_d.and_hit;
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign src.or_hit  = state_q.or_hit;
    assign src.and_hit = state_q.and_hit;
    assign src.trig    = state_q.trig;

    // An empty AND mask gives no AND result.
    and_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        src.and_mask == 32'h0 |=> !src.and_hit)
        else $error("AND result with empty AND mask");

    // Analog input alone in the AND mask follows the input.
    and_analog_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (src.and_mask == 32'h2) |=> (src.and_hit == $past(src.analog_ext)))
        else $error("AND result does not follow analog input");

    // TTL A counts only while line A is a trigger input.
    and_ttl_a_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (src.and_mask == 32'h4) |=> (src.and_hit == $past(src.ttl_ext_a & src.line_a_trig)))
        else $error("AND result wrong for TTL input A");

    // TTL B counts only while line B is a trigger input.
    and_ttl_b_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (src.and_mask == 32'h8) |=> (src.and_hit == $past(src.ttl_ext_b & src.line_b_trig)))
        else $error("AND result wrong for TTL input B");

    // Software trigger in the OR mask fires once running.
    or_soft_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (src.gen_or_mask[0] && src.soft_trig) |=> (src.or_hit && src.trig))
        else $error("Software trigger did not fire");

    // Final trigger is exactly the OR of both results.
    final_or_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        src.trig == (src.or_hit | src.and_hit))
        else $error("Final trigger not OR of both results");
endmodule

// *** src/trig_mask_top.sv ***
// Trigger source mask registers and routing to the trigger engine.
//
// Operation
// - Channel OR mask, one bit per channel.
// - Channel availability mask, read only.
// - General AND mask, read and write.
// - General AND availability mask, read only.
// - Zero AND mask selects no source.
// - Bit 2h selects analog external input.
// - Bit 4h selects TTL A, line set.
// - Bit 8h selects TTL B, line set.
// - Software trigger never enters the AND.
// - Sources are independent bits, one write.
// - General OR bit 1h selects software trigger.
`timescale 1ns/1ps
module trig_mask_top #(
    parameter int unsigned CHAN_COUNT = 32  // Channel trigger sources present.
) (
    input  wire logic        clk_i,          // Card clock, 10 MHz.
    input  wire logic        rst_n_i,        // Asynchronous reset, active low.
    input  wire logic [15:0] reg_addr_i,     // Register number.
    input  wire logic        reg_wr_i,       // Write strobe, one cycle.
    input  wire logic        reg_rd_i,       // Read strobe, one cycle.
    input  wire logic [31:0] reg_wdata_i,    // Write data.
    input  wire logic [31:0] chan_trig_i,    // Channel trigger events.
    input  wire logic        run_i,          // Card started and armed.
    input  wire logic        analog_ext_i,   // Analog comparator pin.
    input  wire logic        ttl_ext_a_i,    // TTL trigger on multi line A.
    input  wire logic        ttl_ext_b_i,    // TTL trigger on multi line B.
    input  wire logic        line_a_trig_i,  // Multi line A set as trigger input.
    input  wire logic        line_b_trig_i,  // Multi line B set as trigger input.
    output logic [31:0]      reg_rdata_o,    // Read data.
    output logic             reg_ack_o,      // Access answered.
    output logic             or_hit_o,       // OR combination result.
    output logic             and_hit_o,      // AND combination result.
    output logic             trig_o          // Final trigger.
);
    // The channel count must fit the 32-bit mask.
    if (CHAN_COUNT < 1 || CHAN_COUNT > 32) begin : g_bad_count
        $error("CHAN_COUNT must lie between 1 and 32");
    end

    // Channel sources that exist on this card.
    localparam logic [31:0] CH_AVAIL = 32'hffff_ffff >> (32 - CHAN_COUNT);

    // All register state of this module except the reset release stages.
    typedef struct packed {
        logic [31:0] gen_or;   // General OR selection.
        logic [31:0] and_sel;  // General AND selection.
        logic [31:0] ch_or;    // Channel OR selection.
        logic [31:0] rdata;    // Read data held for the answer.
        logic        ack;      // Answer pulse.
    } state_s;

    state_s                                state_q;
    state_s                                state_d;
    logic   [1:0]                          rst_sync_q;  // Reset release stages.
    logic                                  rst_n_q;     // Released reset.
    logic   [trig_mask_pkg::EXT_PINS-1:0]  pins_raw;    // Pin inputs before sync.
    logic   [trig_mask_pkg::EXT_PINS-1:0]  pins_sync;   // Pin inputs after sync.
    logic                                  access;      // Any strobe this cycle.

    trig_src_if src ();

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n_q = rst_sync_q[1];

    // Pin inputs pass two flops before any logic reads them.
    assign pins_raw = {ttl_ext_b_i, ttl_ext_a_i, analog_ext_i};

    pin_sync #(
        .WIDTH (trig_mask_pkg::EXT_PINS)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_q),
        .pin_i   (pins_raw),
        .sync_o  (pins_sync)
    );

    assign access = reg_wr_i | reg_rd_i;

    // Register writes, read mux and answer pulse.
    always_comb begin
        state_d     = state_q;
        state_d.ack = access;
        if (reg_wr_i) begin
            // Each source is its own bit, so one write sets any mix.
            case (reg_addr_i)
                trig_mask_pkg::OFS_GEN_OR_SELECT: begin
                    state_d.gen_or = reg_wdata_i & trig_mask_pkg::GEN_OR_AVAIL;
                end
                trig_mask_pkg::OFS_AND_SELECT: begin
                    // Only hardware sources can be stored here.
                    state_d.and_sel = reg_wdata_i & trig_mask_pkg::AND_AVAIL;
                end
                trig_mask_pkg::OFS_CH_OR_SELECT: begin
                    state_d.ch_or = reg_wdata_i & CH_AVAIL;
                end
                default: begin
                    // Writes to read-only or unknown numbers are ignored.
                    state_d.ack = 1'b1;
                end
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                trig_mask_pkg::OFS_GEN_OR_AVAIL: begin
                    state_d.rdata = trig_mask_pkg::GEN_OR_AVAIL;
                end
                trig_mask_pkg::OFS_GEN_OR_SELECT: begin
                    state_d.rdata = state_q.gen_or;
                end
                trig_mask_pkg::OFS_AND_AVAIL: begin
                    state_d.rdata = trig_mask_pkg::AND_AVAIL;
                end
                trig_mask_pkg::OFS_AND_SELECT: begin
                    state_d.rdata = state_q.and_sel;
                end
                trig_mask_pkg::OFS_CH_OR_AVAIL: begin
                    state_d.rdata = CH_AVAIL;
                end
                trig_mask_pkg::OFS_CH_OR_SELECT: begin
                    state_d.rdata = state_q.ch_or;
                end
                default: begin
                    // Unknown numbers read as zero.
                    state_d.rdata = trig_mask_pkg::NO_SOURCE_CODE;
                end
            endcase
        end
    end

    // State register, cleared by the released reset except the general OR select, which it sets to the software trigger bit.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q.gen_or  <= trig_mask_pkg::GEN_OR_RESET;
            state_q.and_sel <= trig_mask_pkg::AND_RESET;
            state_q.ch_or   <= trig_mask_pkg::CH_OR_RESET;
            state_q.rdata   <= 32'h0;
            state_q.ack     <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // Feed masks and sources to the combiner.
    assign src.gen_or_mask  = state_q.gen_or;
    assign src.and_mask     = state_q.and_sel;
    assign src.chan_or_mask = state_q.ch_or;
    assign src.chan_trig    = chan_trig_i & CH_AVAIL;
    assign src.soft_trig    = run_i;
    assign src.analog_ext   = pins_sync[0];
    assign src.ttl_ext_a    = pins_sync[1];
    assign src.ttl_ext_b    = pins_sync[2];
    assign src.line_a_trig  = line_a_trig_i;
    assign src.line_b_trig  = line_b_trig_i;

    trig_combine u_combine (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_q),
        .src     (src)
    );

    // Outputs come straight from flops.
    assign reg_rdata_o = state_q.rdata;
    assign reg_ack_o   = state_q.ack;
    assign or_hit_o    = src.or_hit;
    assign and_hit_o   = src.and_hit;
    assign trig_o      = src.trig;

    // A channel OR write, a cycle without a write, then a read returns it masked to present channels.
    ch_or_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_wr_i && reg_addr_i == 16'h9e0c)
        ##1 !reg_wr_i
        ##1 (reg_rd_i && reg_addr_i == 16'h9e0c && !reg_wr_i)
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & CH_AVAIL))
        else $error("Channel OR mask readback wrong");

    // Channel availability reads the present channels.
    ch_avail_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_rd_i && reg_addr_i == 16'h9e02) |=> (reg_ack_o && reg_rdata_o == CH_AVAIL))
        else $error("Channel availability read wrong");

    // An AND write lands in the mask one cycle later.
    and_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_wr_i && reg_addr_i == 16'h9dee)
        |=> src.and_mask == ($past(reg_wdata_i) & 32'h0000_000e))
        else $error("AND mask write not stored");

    // AND availability reads the three hardware sources.
    and_avail_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_rd_i && reg_addr_i == 16'h9de4) |=> reg_rdata_o == 32'h0000_000e)
        else $error("AND availability read wrong");

    // The software bit never sits in the AND mask.
    and_no_soft_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        !src.and_mask[0] && src.and_mask[31:4] == 28'h0)
        else $error("Software or unknown bit in AND mask");

    // A mixed write keeps each source bit on its own.
    mix_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_wr_i && reg_addr_i == 16'h9dee && reg_wdata_i[3:1] == 3'h7)
        |=> src.and_mask[3:1] == 3'h7)
        else $error("Combined source write lost a bit");

    // The general OR mask holds the software trigger after reset.
    gen_or_rst_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        $rose(rst_n_q) |-> src.gen_or_mask == 32'h0000_0001)
        else $error("General OR mask reset value wrong");

    // Every strobe is answered on the next cycle.
    reg_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
        (reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("Register access not answered");
endmodule

// *** tb/host_model.sv ***
// Host software model that drives the register port and the multi line settings.
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i,        // Card clock.
    input  wire logic [31:0] reg_rdata_i,  // Read data from the device.
    input  wire logic        reg_ack_i,    // Access answered.
    output logic      [15:0] reg_addr_o,   // Register number.
    output logic             reg_wr_o,     // Write strobe.
    output logic             reg_rd_o,     // Read strobe.
    output logic      [31:0] reg_wdata_o,  // Write data.
    output logic             line_a_trig_o, // Multi line A set as trigger input.
    output logic             line_b_trig_o  // Multi line B set as trigger input.
);
    // Everything starts idle with both multi lines left as plain lines.
    initial begin
        reg_addr_o    = 16'h0000;
        reg_wr_o      = 1'b0;
        reg_rd_o      = 1'b0;
        reg_wdata_o   = 32'h0000_0000;
        line_a_trig_o = 1'b0;
        line_b_trig_o = 1'b0;
    end

    // One access: drive after an edge, hold for the taking edge, then take the answer.
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data,
                          output logic [31:0] rdata, output logic ack);
        @(posedge clk_i);
        #10;
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = wr;
        reg_rd_o    = ~wr;
        @(posedge clk_i);
        #10;
        rdata       = reg_rdata_i;
        ack         = reg_ack_i;
        // Released lines show the inverse so a stale value never looks valid.
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask

    // Software sets each multi line as a trigger input before using its TTL source.
    task automatic set_lines(input logic a, input logic b);
        line_a_trig_o = a;
        line_b_trig_o = b;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the trigger source mask logic.
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned CHANS = 20;  // Fewer channels so the unused bits are tested.
    localparam logic [31:0] CH_AVAIL = 32'h000f_ffff;  // Low CHANS bits set.

    logic        clk;          // Card clock, 100 ns period.
    logic        rst_n;        // Active low reset.
    logic [15:0] reg_addr;     // Register number from the host.
    logic        reg_wr;       // Write strobe.
    logic        reg_rd;       // Read strobe.
    logic [31:0] reg_wdata;    // Write data.
    logic [31:0] chan_trig;    // Channel trigger events.
    logic        run;          // Card started.
    logic        analog_ext;   // Analog comparator pin.
    logic        ttl_a;        // TTL pin A.
    logic        ttl_b;        // TTL pin B.
    logic        line_a;       // Multi line A as trigger input.
    logic        line_b;       // Multi line B as trigger input.
    logic [31:0] reg_rdata;    // Read data.
    logic        reg_ack;      // Access answered.
    logic        or_hit;       // OR combination.
    logic        and_hit;      // AND combination.
    logic        trig;         // Final trigger.
    int          fail_count;   // Mismatches seen.
    int          checks;       // Comparisons made.
    int          cycles;       // Clock cycles for the timeout.

    trig_mask_top #(.CHAN_COUNT(CHANS)) u_trig_mask_top (
        .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .chan_trig_i(chan_trig), .run_i(run),
        .analog_ext_i(analog_ext), .ttl_ext_a_i(ttl_a), .ttl_ext_b_i(ttl_b),
        .line_a_trig_i(line_a), .line_b_trig_i(line_b), .reg_rdata_o(reg_rdata),
        .reg_ack_o(reg_ack), .or_hit_o(or_hit), .and_hit_o(and_hit), .trig_o(trig));

    host_model u_host_model (
        .clk_i(clk), .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack), .reg_addr_o(reg_addr),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
        .line_a_trig_o(line_a), .line_b_trig_o(line_b));

    // Clock generator.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares a word result.
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compares a single bit result.
    task automatic check_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Writes a register and checks the answer.
    task automatic wr(input logic [15:0] addr, input logic [31:0] data);
        logic [31:0] q;
        logic        ack;
        u_host_model.access(1'b1, addr, data, q, ack);
        check_bit("write ack", 1'b1, ack);
    endtask

    // Reads a register and checks answer and data.
    task automatic rd(input string name, input logic [15:0] addr, input logic [31:0] exp);
        logic [31:0] q;
        logic        ack;
        u_host_model.access(1'b0, addr, 32'h0000_0000, q, ack);
        check_bit("read ack", 1'b1, ack);
        check_word(name, exp, q);
    endtask

    // Lets pin changes pass the synchroniser, then checks all three results.
    task automatic hits(input logic exp_or, input logic exp_and);
        repeat (4) @(posedge clk);
        #10;
        check_bit("or_hit", exp_or, or_hit);
        check_bit("and_hit", exp_and, and_hit);
        check_bit("trig", exp_or | exp_and, trig);
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end

    // Main sequence.
    initial begin
        fail_count = 0;
        checks     = 0;
        cycles     = 0;
        rst_n      = 1'b0;
        chan_trig  = 32'h0000_0000;
        run        = 1'b0;
        analog_ext = 1'b0;
        ttl_a      = 1'b0;
        ttl_b      = 1'b0;
        repeat (10) @(posedge clk);
        #10;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        // Reset values and availability masks.
        rd("and select", trig_mask_pkg::OFS_AND_SELECT, 32'h0000_0000);
        rd("and avail", trig_mask_pkg::OFS_AND_AVAIL, 32'h0000_000e);
        rd("chan avail", trig_mask_pkg::OFS_CH_OR_AVAIL, CH_AVAIL);
        rd("chan select", trig_mask_pkg::OFS_CH_OR_SELECT, 32'h0000_0000);
        rd("or select", trig_mask_pkg::OFS_GEN_OR_SELECT, 32'h0000_0001);
        rd("or avail", trig_mask_pkg::OFS_GEN_OR_AVAIL, 32'h0000_000f);
        // Software trigger follows the run level through the OR mask.
        run = 1'b1;
        hits(1'b1, 1'b0);
        // Independent bits, unavailable bits dropped, read-only places kept.
        wr(trig_mask_pkg::OFS_CH_OR_SELECT, 32'hffff_ffff);
        rd("chan select all", trig_mask_pkg::OFS_CH_OR_SELECT, CH_AVAIL);
        wr(trig_mask_pkg::OFS_CH_OR_SELECT, 32'h8000_0021);
        rd("chan select top", trig_mask_pkg::OFS_CH_OR_SELECT, 32'h0000_0021);
        wr(trig_mask_pkg::OFS_CH_OR_AVAIL, 32'h0000_0000);
        rd("chan avail kept", trig_mask_pkg::OFS_CH_OR_AVAIL, CH_AVAIL);
        wr(trig_mask_pkg::OFS_AND_SELECT, 32'h0000_000f);
        rd("and no soft", trig_mask_pkg::OFS_AND_SELECT, 32'h0000_000e);
        wr(trig_mask_pkg::OFS_AND_AVAIL, 32'h0000_0000);
        rd("and avail kept", trig_mask_pkg::OFS_AND_AVAIL, 32'h0000_000e);
        rd("unmapped", 16'h9e20, 32'h0000_0000);
        // Software trigger off: with AND 0xe and no pin high nothing fires.
        wr(trig_mask_pkg::OFS_GEN_OR_SELECT, trig_mask_pkg::NO_SOURCE_CODE);
        hits(1'b0, 1'b0);
        // Channel OR path: enabled channel fires, channel beyond count does not.
        chan_trig = 32'h0200_0000;
        hits(1'b0, 1'b0);
        chan_trig = 32'h0000_0020;
        hits(1'b1, 1'b0);
        chan_trig = 32'h0000_0000;
        // Zero AND mask selects nothing even with all sources active.
        wr(trig_mask_pkg::OFS_AND_SELECT, trig_mask_pkg::NO_SOURCE_CODE);
        u_host_model.set_lines(1'b1, 1'b1);
        analog_ext = 1'b1;
        ttl_a      = 1'b1;
        ttl_b      = 1'b1;
        hits(1'b0, 1'b0);
        // Analog input alone.
        wr(trig_mask_pkg::OFS_AND_SELECT, trig_mask_pkg::ANALOG_EXT_BIT);
        hits(1'b0, 1'b1);
        analog_ext = 1'b0;
        hits(1'b0, 1'b0);
        // TTL A needs its line set as trigger input.
        wr(trig_mask_pkg::OFS_AND_SELECT, trig_mask_pkg::TTL_EXT_A_BIT);
        hits(1'b0, 1'b1);
        u_host_model.set_lines(1'b0, 1'b1);
        hits(1'b0, 1'b0);
        // TTL B needs its line set as trigger input.
        wr(trig_mask_pkg::OFS_AND_SELECT, trig_mask_pkg::TTL_EXT_B_BIT);
        hits(1'b0, 1'b1);
        u_host_model.set_lines(1'b1, 1'b0);
        hits(1'b0, 1'b0);
        // All three selected: every one must be met.
        u_host_model.set_lines(1'b1, 1'b1);
        analog_ext = 1'b1;
        wr(trig_mask_pkg::OFS_AND_SELECT, 32'h0000_000e);
        hits(1'b0, 1'b1);
        ttl_b = 1'b0;
        hits(1'b0, 1'b0);
        // General OR keeps only its available bits, and the analog input alone fires the OR side.
        wr(trig_mask_pkg::OFS_GEN_OR_SELECT, 32'hffff_fff2);
        rd("or select masked", trig_mask_pkg::OFS_GEN_OR_SELECT, 32'h0000_0002);
        hits(1'b1, 1'b0);
        final_report();
    end
endmodule
